// ---- hdl/lfs_consts.svh ----
`ifndef LFS_CONSTS_SVH
`define LFS_CONSTS_SVH

// clock rate in MHz
`define LFS_CLK_MHZ         100
// deglitch times, nanoseconds, as printed (typical)
`define LFS_OPEN_DEG_NS     125000
`define LFS_SG_DEG_NS       125000
`define LFS_TSD_DEG_NS      50000
`define LFS_RECOVER_DEG_NS  16000
// cycle counts derived from time and clock rate
`define LFS_OPEN_DEG_CYC    ((`LFS_OPEN_DEG_NS * `LFS_CLK_MHZ) / 1000)
`define LFS_SG_DEG_CYC      ((`LFS_SG_DEG_NS * `LFS_CLK_MHZ) / 1000)
`define LFS_TSD_DEG_CYC     ((`LFS_TSD_DEG_NS * `LFS_CLK_MHZ) / 1000)
`define LFS_RECOVER_DEG_CYC ((`LFS_RECOVER_DEG_NS * `LFS_CLK_MHZ) / 1000)
// counter width
`define LFS_CNT_W           16
// apb answers
`define LFS_APB_RDATA_RST   32'h0000_0000

// register byte offsets
`define LFS_CTRL_OFS        12'h000
`define LFS_STAT_OFS        12'h004
`define LFS_TIME_OFS        12'h008

// control field positions
`define LFS_CTRL_DIMM       0
`define LFS_CTRL_DIAG       1
// status field positions
`define LFS_ST_OPEN         0
`define LFS_ST_SHORT        1
`define LFS_ST_THERM        2
`define LFS_ST_EXTLOW       3
`define LFS_ST_OUTEN        4
`define LFS_ST_RETRY        5
`define LFS_ST_PULL         6
`define LFS_ST_POR          7
`define LFS_ST_MODE_LO      8

`endif

// ---- hdl/lfs_deglitch.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "lfs_consts.svh"
module lfs_deglitch #(
    parameter int CNT_W = `LFS_CNT_W
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // condition and length
    input  wire logic             cond,
    input  wire logic [CNT_W-1:0] limit,
    // condition persisted for limit cycles
    output logic                  done
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    wire              at_limit = (cnt_reg >= limit);

    // counts only while the condition persists, clears when it drops
    assign cnt_next = !cond ? '0 : (at_limit ? cnt_reg : cnt_reg + 1'b1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            done    <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            done    <= cond && (cnt_next >= limit);
        end
    end
endmodule
`default_nettype wire

// ---- hdl/lfs_pkg.sv ----
package lfs_pkg;
    // supervisor operating mode
    typedef enum logic [2:0] {
        LFS_OFF,
        LFS_NORMAL,
        LFS_OPEN_FLT,
        LFS_SHORT_FLT,
        LFS_THERM_FLT,
        LFS_BUS_LOW
    } lfs_mode_t;
endpackage

// ---- hdl/lfs_supervisor.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "lfs_consts.svh"
// Operation
// - stay in reset until the supply comparator shows the rising power-on level
// - external low on fault bus disables output and enters low-power state
// - any local fault pulls the shared active-low fault line with the current sink
// - dimming high enables current; low disables current and diagnostics
// - supply below falling power-on level turns output current off
// - open detection runs only with open_diag_enable high and output enabled
// - short to battery is treated exactly as an open fault
// - headroom-low held for open deglitch time flags open fault and pulls line
// - headroom above upper open level before expiry clears the open timer
// - after open fault keep output with dimming high, retry current when low
// - open condition gone returns to normal and releases the line
// - output-low held for short deglitch time flags short fault and pulls line
// - output above upper short level during deglitch resets the short timer
// - short fault switches normal output off, sources retry current always
// - in short retry, output above lower short level clears fault
// - thermal trip turns output off, pulls line, resumes on hysteresis release
// - open_diag_enable low masks only open detection
// - open and short deglitch intervals 80 to 175 us, typically 125
// - thermal indication filtered by a 50 us deglitch timer
// - fault recovery qualified by a 16 us deglitch timer
// - fault line driven low externally keeps output off until line high
module lfs_supervisor #(
    parameter int CNT_W       = `LFS_CNT_W,
    parameter int OPEN_CYC    = `LFS_OPEN_DEG_CYC,
    parameter int SG_CYC      = `LFS_SG_DEG_CYC,
    parameter int TSD_CYC     = `LFS_TSD_DEG_CYC,
    parameter int RECOVER_CYC = `LFS_RECOVER_DEG_CYC
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // analog comparators, asynchronous
    input  wire logic        supply_ok,
    input  wire logic        headroom_low,
    input  wire logic        headroom_high,
    input  wire logic        out_low,
    input  wire logic        out_above_lower,
    input  wire logic        out_above_upper,
    input  wire logic        thermal_trip_level,
    input  wire logic        thermal_release,
    // shared open-drain fault bus
    input  wire logic        fault_bus_in,
    output logic             fault_bus_out,
    output logic             fault_bus_oe_n,
    // driver controls
    output logic             drive_enable,
    output logic             retry_enable,
    output logic             low_power
);
    import lfs_pkg::*;

    localparam logic [CNT_W-1:0] OPEN_LIM = CNT_W'(OPEN_CYC);
    localparam logic [CNT_W-1:0] SG_LIM   = CNT_W'(SG_CYC);
    localparam logic [CNT_W-1:0] TSD_LIM  = CNT_W'(TSD_CYC);
    localparam logic [CNT_W-1:0] REC_LIM  = CNT_W'(RECOVER_CYC);

    // synchronised comparator inputs
    logic [8:0] raw_in;
    logic [8:0] syn;
    assign raw_in = {fault_bus_in, thermal_release, thermal_trip_level, out_above_upper,
                     out_above_lower, out_low, headroom_high, headroom_low, supply_ok};

    lfs_sync #(.WIDTH(9)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (raw_in),
        .sync_out (syn)
    );

    wire s_supply   = syn[0];
    wire s_hr_low   = syn[1];
    wire s_hr_high  = syn[2];
    wire s_out_low  = syn[3];
    wire s_out_lo2  = syn[4];
    wire s_out_hi   = syn[5];
    wire s_therm    = syn[6];
    wire s_rel      = syn[7];
    wire s_bus_high = syn[8];

    // software controls, mode and sticky status
    logic      dimm_reg;
    logic      diag_reg;
    lfs_mode_t mode_reg;
    lfs_mode_t mode_next;
    logic      open_hit_reg;
    logic      open_hit_next;
    logic      short_hit_reg;
    logic      short_hit_next;
    logic      therm_hit_reg;
    logic      therm_hit_next;
    logic      bus_low_seen_reg;
    logic [1:0] own_pull_hist_reg;

    // apb decode
    wire apb_acc  = psel && penable;
    wire apb_wr   = apb_acc && pwrite;
    wire hit_ctrl = (paddr == `LFS_CTRL_OFS);
    wire hit_stat = (paddr == `LFS_STAT_OFS);
    wire hit_time = (paddr == `LFS_TIME_OFS);
    wire hit_any  = hit_ctrl || hit_stat || hit_time;

    // own fault pulling and external low detection
    wire pulling   = (mode_reg == LFS_OPEN_FLT) || (mode_reg == LFS_SHORT_FLT) ||
                     (mode_reg == LFS_THERM_FLT);
    // our own release reaches the synchronised bus level two cycles late; mask that window
    wire ext_low   = !s_bus_high && !pulling && !(|own_pull_hist_reg);
    wire outen_now = (mode_reg == LFS_NORMAL || mode_reg == LFS_OPEN_FLT) && dimm_reg;

    // deglitch conditions
    wire open_cond  = s_hr_low && !s_hr_high && diag_reg && outen_now
                      && mode_reg == LFS_NORMAL;
    wire short_cond = s_out_low && !s_out_hi && outen_now;
    wire therm_cond = s_therm && s_supply;
    wire rec_cond   = (mode_reg == LFS_OPEN_FLT  && s_hr_high) ||
                      (mode_reg == LFS_SHORT_FLT && s_out_lo2) ||
                      (mode_reg == LFS_THERM_FLT && s_rel) ||
                      (mode_reg == LFS_BUS_LOW   && s_bus_high);

    logic open_done;
    logic short_done;
    logic therm_done;
    logic rec_done;
    logic [3:0] dg_cond;
    logic [3:0] dg_done;
    logic [CNT_W-1:0] dg_lim [4];
    assign dg_cond   = {rec_cond, therm_cond, short_cond, open_cond};
    assign dg_lim[0] = OPEN_LIM;
    assign dg_lim[1] = SG_LIM;
    assign dg_lim[2] = TSD_LIM;
    assign dg_lim[3] = REC_LIM;
    assign open_done  = dg_done[0];
    assign short_done = dg_done[1];
    assign therm_done = dg_done[2];
    assign rec_done   = dg_done[3];

    // one counter per deglitched condition
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_dg
            lfs_deglitch #(.CNT_W(CNT_W)) u_dg (
                .pclk    (pclk),
                .presetn (presetn),
                .cond    (dg_cond[gi]),
                .limit   (dg_lim[gi]),
                .done    (dg_done[gi])
            );
        end
    endgenerate

    // mode sequencing, thermal first, then short, then open
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            LFS_OFF: begin
                if (s_supply) begin
                    mode_next = LFS_NORMAL;
                end
            end
            LFS_NORMAL: begin
                if (therm_done) begin
                    mode_next = LFS_THERM_FLT;
                end else if (short_done) begin
                    mode_next = LFS_SHORT_FLT;
                end else if (open_done) begin
                    mode_next = LFS_OPEN_FLT;
                end else if (ext_low) begin
                    mode_next = LFS_BUS_LOW;
                end
            end
            LFS_OPEN_FLT: begin
                if (therm_done) begin
                    mode_next = LFS_THERM_FLT;
                end else if (short_done) begin
                    mode_next = LFS_SHORT_FLT;
                end else if (rec_done || !diag_reg) begin
                    mode_next = LFS_NORMAL;
                end
            end
            LFS_SHORT_FLT: begin
                if (therm_done) begin
                    mode_next = LFS_THERM_FLT;
                end else if (rec_done) begin
                    mode_next = LFS_NORMAL;
                end
            end
            LFS_THERM_FLT: begin
                if (rec_done) begin
                    mode_next = LFS_NORMAL;
                end
            end
            LFS_BUS_LOW: begin
                if (therm_done) begin
                    mode_next = LFS_THERM_FLT;
                end else if (rec_done) begin
                    mode_next = LFS_NORMAL;
                end
            end
            default: begin
                mode_next = LFS_OFF;
            end
        endcase
        if (!s_supply) begin
            mode_next = LFS_OFF;
        end
    end

    // sticky status, set wins over software clear
    wire clr_wr = apb_wr && hit_stat;
    assign open_hit_next  = (mode_next == LFS_OPEN_FLT && mode_reg != LFS_OPEN_FLT) ||
                            (open_hit_reg && !(clr_wr && pwdata[`LFS_ST_OPEN]));
    assign short_hit_next = (mode_next == LFS_SHORT_FLT && mode_reg != LFS_SHORT_FLT) ||
                            (short_hit_reg && !(clr_wr && pwdata[`LFS_ST_SHORT]));
    assign therm_hit_next = (mode_next == LFS_THERM_FLT && mode_reg != LFS_THERM_FLT) ||
                            (therm_hit_reg && !(clr_wr && pwdata[`LFS_ST_THERM]));

    // output controls for the next mode
    wire nx_pull  = (mode_next == LFS_OPEN_FLT) || (mode_next == LFS_SHORT_FLT) ||
                    (mode_next == LFS_THERM_FLT);
    wire nx_drive = (mode_next == LFS_NORMAL || mode_next == LFS_OPEN_FLT) && dimm_reg;
    wire nx_retry = (mode_next == LFS_SHORT_FLT) ||
                    (mode_next == LFS_OPEN_FLT && !dimm_reg);
    wire nx_lowp  = (mode_next == LFS_BUS_LOW) || (mode_next == LFS_OFF);

    // read data selection
    wire [31:0] stat_word = {20'h00000, 1'b0, mode_reg,
                             s_supply, pulling, retry_enable, drive_enable,
                             bus_low_seen_reg, therm_hit_reg, short_hit_reg, open_hit_reg};
    wire [31:0] rd_mux = hit_ctrl ? {30'h0, diag_reg, dimm_reg} :
                         hit_stat ? stat_word :
                         hit_time ? {{(32-CNT_W){1'b0}}, OPEN_LIM} : `LFS_APB_RDATA_RST;

    // state and status registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg         <= LFS_OFF;
            open_hit_reg     <= 1'b0;
            short_hit_reg    <= 1'b0;
            therm_hit_reg    <= 1'b0;
            bus_low_seen_reg <= 1'b0;
            own_pull_hist_reg <= 2'b00;
        end else begin
            mode_reg         <= mode_next;
            open_hit_reg     <= open_hit_next;
            short_hit_reg    <= short_hit_next;
            therm_hit_reg    <= therm_hit_next;
            bus_low_seen_reg <= (mode_next == LFS_BUS_LOW && mode_reg != LFS_BUS_LOW) ||
                                (bus_low_seen_reg && !(clr_wr && pwdata[`LFS_ST_EXTLOW]));
            own_pull_hist_reg <= {own_pull_hist_reg[0], !fault_bus_oe_n};
        end
    end

    // pin outputs from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_enable   <= 1'b0;
            retry_enable   <= 1'b0;
            low_power      <= 1'b1;
            fault_bus_out  <= 1'b0;
            fault_bus_oe_n <= 1'b1;
        end else begin
            drive_enable   <= nx_drive;
            retry_enable   <= nx_retry;
            low_power      <= nx_lowp;
            fault_bus_out  <= 1'b0;
            fault_bus_oe_n <= !nx_pull;
        end
    end

    // apb slave: zero wait, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dimm_reg <= 1'b0;
            diag_reg <= 1'b0;
            prdata   <= `LFS_APB_RDATA_RST;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit_any;
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : `LFS_APB_RDATA_RST;
            if (apb_wr && pready && hit_ctrl) begin
                dimm_reg <= pwdata[`LFS_CTRL_DIMM];
                diag_reg <= pwdata[`LFS_CTRL_DIAG];
            end
        end
    end
endmodule
`default_nettype wire

// ---- hdl/lfs_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module lfs_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // asynchronous in, synchronised out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // two flip-flop synchroniser, first stage read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ---- test/lfs_far_side.sv ----
`timescale 1ns/1ns
`default_nettype none
module lfs_far_side (
    // load faults, heat and peer pull from the bench
    input wire logic [1:0] flt,
    input wire logic       hot,
    input wire logic       peer_pull,
    // device outputs
    input wire logic       drive_enable,
    input wire logic       retry_enable,
    input wire logic       fault_bus_out,
    input wire logic       fault_bus_oe_n,
    // comparator levels
    output logic           headroom_low,
    output logic           headroom_high,
    output logic           out_low,
    output logic           out_above_lower,
    output logic           out_above_upper,
    output logic           thermal_trip_level,
    output logic           thermal_release,
    // resolved bus level
    output logic           fault_bus_in
);
    logic out_up;
    // an open string or a short to battery collapses the headroom alike
    assign headroom_low  = flt[0];
    assign headroom_high = !flt[0] && drive_enable;
    // output rises while current flows or flt[0] lifts it, and no short holds it down
    assign out_up          = !flt[1] && (flt[0] || drive_enable || retry_enable);
    assign out_low         = !out_up;
    assign out_above_lower = out_up;
    assign out_above_upper = out_up;
    // junction temperature
    assign thermal_trip_level = hot;
    assign thermal_release    = !hot;
    // pulled-up bus, low while any party sinks it
    assign fault_bus_in = !peer_pull && (fault_bus_oe_n || fault_bus_out);
endmodule
`default_nettype wire

// ---- test/lfs_sup_chk_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module lfs_sup_chk #(
    parameter int SG_CYC  = 20,
    parameter int TSD_CYC = 10
) (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // comparators
    input wire logic        supply_ok,
    input wire logic        out_low,
    input wire logic        out_above_upper,
    input wire logic        thermal_trip_level,
    // fault bus and drivers
    input wire logic        fault_bus_in,
    input wire logic        fault_bus_out,
    input wire logic        fault_bus_oe_n,
    input wire logic        drive_enable,
    input wire logic        retry_enable,
    input wire logic        low_power
);
    int sg_run;
    int hot_run;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // how long a short has lasted with drive enabled, or a trip until the output is off and the line pulled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sg_run  <= 0;
            hot_run <= 0;
        end else begin
            sg_run  <= (out_low && !out_above_upper && drive_enable) ? sg_run + 1 : 0;
            hot_run <= (thermal_trip_level && supply_ok && (drive_enable || fault_bus_oe_n)) ? hot_run + 1 : 0;
        end
    end
    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    access_only_a: assert property (pready |-> psel && penable)
        else $error("answer outside access");
    bad_addr_a: assert property (pready && paddr > 12'h008 |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    supply_off_a: assert property (!supply_ok [*5] |-> !drive_enable && !retry_enable)
        else $error("current on without supply");
    power_gate_a: assert property ($rose(drive_enable) |-> $past(supply_ok, 3))
        else $error("drive before supply");
    bus_low_a: assert property ((fault_bus_oe_n && !fault_bus_in) [*5] |-> !drive_enable && low_power)
        else $error("drive while bus held low");
    short_bound_a: assert property (sg_run <= SG_CYC + 8)
        else $error("short not flagged in time");
    therm_bound_a: assert property (hot_run <= TSD_CYC + 10)
        else $error("trip not handled in time");
    one_source_a: assert property (retry_enable |-> !drive_enable)
        else $error("retry and drive together");
    pull_low_a: assert property (!fault_bus_oe_n |-> !fault_bus_out)
        else $error("bus pulled high");
endmodule
bind lfs_supervisor lfs_sup_chk #(.SG_CYC(SG_CYC), .TSD_CYC(TSD_CYC)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok),
    .out_low(out_low), .out_above_upper(out_above_upper), .thermal_trip_level(thermal_trip_level),
    .fault_bus_in(fault_bus_in), .fault_bus_out(fault_bus_out), .fault_bus_oe_n(fault_bus_oe_n),
    .drive_enable(drive_enable), .retry_enable(retry_enable), .low_power(low_power));
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int OPEN_CYC = 20;
    localparam int SG_CYC   = 20;
    localparam int TSD_CYC  = 10;
    localparam int REC_CYC  = 5;
    // bench-driven inputs
    logic        pclk      = 1'b0;
    logic        presetn   = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'h0000_0000;
    logic        supply_ok = 1'b0;
    logic [1:0]  flt       = 2'b00;
    logic        hot       = 1'b0;
    logic        peer_pull = 1'b0;
    // outputs
    logic [31:0] prdata;
    logic        pready, pslverr, fault_bus_out, fault_bus_oe_n, drive_enable, retry_enable, low_power;
    logic        headroom_low, headroom_high, out_low, out_above_lower, out_above_upper;
    logic        thermal_trip_level, thermal_release, fault_bus_in;
    logic [32:0] exp_q[$];
    logic [31:0] d;
    int          num_errors = 0;
    int          checked = 0;
    int          cyc = 0;

    lfs_supervisor #(.OPEN_CYC(OPEN_CYC), .SG_CYC(SG_CYC), .TSD_CYC(TSD_CYC), .RECOVER_CYC(REC_CYC)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supply_ok(supply_ok), .headroom_low(headroom_low), .headroom_high(headroom_high),
        .out_low(out_low), .out_above_lower(out_above_lower), .out_above_upper(out_above_upper),
        .thermal_trip_level(thermal_trip_level), .thermal_release(thermal_release),
        .fault_bus_in(fault_bus_in), .fault_bus_out(fault_bus_out), .fault_bus_oe_n(fault_bus_oe_n),
        .drive_enable(drive_enable), .retry_enable(retry_enable), .low_power(low_power));
    lfs_far_side u_far (
        .flt(flt), .hot(hot), .peer_pull(peer_pull), .drive_enable(drive_enable),
        .retry_enable(retry_enable), .fault_bus_out(fault_bus_out), .fault_bus_oe_n(fault_bus_oe_n),
        .headroom_low(headroom_low), .headroom_high(headroom_high), .out_low(out_low),
        .out_above_lower(out_above_lower), .out_above_upper(out_above_upper),
        .thermal_trip_level(thermal_trip_level), .thermal_release(thermal_release),
        .fault_bus_in(fault_bus_in));

    // clock
    initial begin
        forever #5 pclk = ~pclk;
    end

    task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one apb transfer; the expected answer goes on the queue
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v, input logic [32:0] e);
        exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic w(input logic [11:0] a, input logic [31:0] v);
        apb(1'b1, a, v, 33'h0);
    endtask

    task automatic r(input logic [11:0] a, input logic [31:0] v);
        apb(1'b0, a, 32'h0, {1'b0, v});
    endtask

    function automatic logic sel(input int k);
        case (k)
            0: return drive_enable;
            1: return retry_enable;
            2: return fault_bus_oe_n;
            default: return low_power;
        endcase
    endfunction

    // wait up to lim cycles for an output level, sampled mid-cycle
    task automatic wait_is(input string nm, input int k, input logic v, input int lim);
        int i;
        i = 0;
        @(negedge pclk);
        while (sel(k) !== v && i < lim) begin
            @(negedge pclk);
            i++;
        end
        check(nm, {32'h0, sel(k)}, {32'h0, v});
        @(posedge pclk);
    endtask

    // answer monitor: oldest expectation against each completed transfer
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            check("apb", {pslverr, prdata}, exp_q.size() ? exp_q.pop_front() : 33'h1_FFFF_FFFF);
        end
    end

    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        void'($urandom(33));
        // idle registers, output held off without supply
        r(12'h000, 32'h0);
        r(12'h004, 32'h0);
        r(12'h008, 32'(OPEN_CYC));
        apb(1'b0, 12'h00C, 32'h0, {1'b1, 32'h0});
        wait_is("low_power", 3, 1'b1, 0);
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            w(12'h000, d);
            r(12'h000, {30'h0, d[1:0]});
        end
        w(12'h000, 32'h0);
        supply_ok <= 1'b1;
        repeat (10) @(posedge pclk);
        wait_is("drive", 0, 1'b0, 0);
        w(12'h000, 32'h3);
        wait_is("drive", 0, 1'b1, 8);
        // open load: flagged, output kept, retry only with dimming low
        flt <= 2'b01;
        wait_is("pull", 2, 1'b0, OPEN_CYC + 10);
        wait_is("drive", 0, 1'b1, 0);
        w(12'h000, 32'h2);
        wait_is("retry", 1, 1'b1, 8);
        w(12'h000, 32'h3);
        flt <= 2'b00;
        wait_is("pull", 2, 1'b1, REC_CYC + 12);
        r(12'h004, 32'h0000_0191);
        w(12'h004, 32'h1);
        r(12'h004, 32'h0000_0190);
        // short pulses, each under the deglitch time
        for (int k = 0; k < 6; k++) begin
            flt <= (k % 2) ? 2'b10 : 2'b01;
            repeat (OPEN_CYC / 2) @(posedge pclk);
            flt <= 2'b00;
            repeat (4) @(posedge pclk);
        end
        r(12'h004, 32'h0000_0190);
        // low headroom with open diagnostics held off
        w(12'h000, 32'h1);
        flt <= 2'b01;
        repeat (OPEN_CYC + 10) @(posedge pclk);
        r(12'h004, 32'h0000_0190);
        // short to ground, still detected with diagnostics off
        flt <= 2'b10;
        wait_is("pull", 2, 1'b0, SG_CYC + 12);
        wait_is("retry", 1, 1'b1, 2);
        w(12'h000, 32'h0);
        repeat (6) @(posedge pclk);
        wait_is("retry", 1, 1'b1, 0);
        flt <= 2'b00;
        wait_is("pull", 2, 1'b1, REC_CYC + 12);
        w(12'h000, 32'h3);
        wait_is("drive", 0, 1'b1, 8);
        // thermal trip and release
        hot <= 1'b1;
        wait_is("drive", 0, 1'b0, TSD_CYC + 12);
        wait_is("pull", 2, 1'b0, 4);
        hot <= 1'b0;
        wait_is("pull", 2, 1'b1, REC_CYC + 12);
        wait_is("drive", 0, 1'b1, 4);
        // a peer holds the bus low
        peer_pull <= 1'b1;
        wait_is("drive", 0, 1'b0, 8);
        wait_is("low_power", 3, 1'b1, 2);
        peer_pull <= 1'b0;
        wait_is("drive", 0, 1'b1, REC_CYC + 12);
        // supply removed
        supply_ok <= 1'b0;
        wait_is("drive", 0, 1'b0, 8);
        wrap_up();
    end
endmodule
`default_nettype wire
